/* File: verilog/frame_state_sequencer.sv */
`timescale 1ns/1ps
module frame_state_sequencer
   import frame_seq_pkg::*;
(
   // clock and hard reset
   input wire logic mclk,
   input wire logic nrst,
   // request pins
   input wire logic exposureRequest,
   input wire logic frameRequest,
   // serial register port
   input wire logic spiCsN,
   input wire logic spiClk,
   input wire logic spiMosi,
   output logic spiMisoOut,
   output logic spiMisoOeN,
   // sequencer status
   output logic [2:0] seqState,
   output logic exposureActive,
   output logic integrating,
   output logic readoutActive,
   output logic softResetActive,
   // active configuration
   output logic [SYNC_COUNT*8-1:0] syncConfig,
   output logic [FRAME_COUNT*8-1:0] frameConfig
);
   localparam int AST_GLOBAL_SAMPLE_STATE_MAX = GLOBAL_SAMPLE_STATE_CYCLES + 1;

   logic [7:0] mem [BANKS][ADDRS];
   logic [1:0] bankSel;
   state_t state;
   state_t next_state;
   logic [CNT_W-1:0] phaseCnt;
   logic [CNT_W-1:0] next_phase;
   logic [CNT_W-1:0] lagCnt;
   logic [CNT_W-1:0] endCnt;
   logic overlapExp;
   logic [7:0] syncActive [SYNC_COUNT];
   logic [SYNC_COUNT*8-1:0] syncShadow;
   logic [FRAME_COUNT*8-1:0] frameShadow;
   logic [4:0] pinLvl;
   logic [4:0] pinRise;
   logic [4:0] pinFall;
   logic wrStb;
   logic [6:0] wrAddr;
   logic [7:0] wrData;
   logic [6:0] rdAddr;
   logic [7:0] rdData;

   // ----------------------------------------
   // pin synchronisers and serial target
   // ----------------------------------------
   // all pins share one sync depth so clock and data stay aligned
   edge_sync #(.WIDTH(5)) u_sync (
      .mclk(mclk),
      .nrst(nrst),
      .din({spiMosi, spiClk, spiCsN, frameRequest, exposureRequest}),
      .level(pinLvl),
      .rise(pinRise),
      .fall(pinFall)
   );

   spi_target u_spi (
      .mclk(mclk),
      .nrst(nrst),
      .csNLvl(pinLvl[2]),
      .sckRise(pinRise[3]),
      .sckFall(pinFall[3]),
      .mosiLvl(pinLvl[4]),
      .wrStb(wrStb),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .rdAddr(rdAddr),
      .rdData(rdData),
      .misoOut(spiMisoOut),
      .misoOeN(spiMisoOeN)
   );

   wire expRise = pinRise[0];
   wire frameRise = pinRise[1];

   // ----------------------------------------
   // register bank
   // ----------------------------------------
   wire cat_t wrCat = regCategory(bankSel, wrAddr);
   wire bankWe = wrStb && wrAddr == ADDR_BANK_SEL;
   wire memWe = wrStb && wrAddr != ADDR_BANK_SEL && wrCat != CAT_READONLY;
   wire bypass = mem[BANK0][ADDR_FRAME_SYNC_BYPASS][CTRL_BIT];
   wire hold = mem[BANK0][ADDR_SYNC_UPDATE_HOLD][CTRL_BIT];
   wire noLag = mem[BANK0][ADDR_START_LAG_DISABLE][CTRL_BIT];
   wire softRstN = mem[BANK0][ADDR_SOFT_RESET_CONTROL][CTRL_BIT];
   // soft reset spares the bank and serial port, hard reset takes all
   wire seqRstN = nrst & softRstN;

   // only the hard reset clears stored values
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int b = 0; b < BANKS; b++)
            for (int a = 0; a < ADDRS; a++)
               mem[b][a] <= REG_RESET;
         mem[BANK0][ADDR_SOFT_RESET_CONTROL] <= SOFT_RESET_DEFAULT;
      end
      else if (memWe)
         mem[bankSel][wrAddr] <= wrData;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         bankSel <= BANK0;
      else if (bankWe)
         bankSel <= wrData[1:0];
   end

   // reads see stored values or the live status byte, never the frame's active copy
   wire [7:0] statusByte = {2'h0, readoutActive, integrating, exposureActive, state};
   wire rdStatus = bankSel == BANK0 && rdAddr == ADDR_STATUS;
   assign rdData = (rdAddr == ADDR_BANK_SEL) ? {6'h00, bankSel} :
                   rdStatus ? statusByte : mem[bankSel][rdAddr];

   // ----------------------------------------
   // sequencer state
   // ----------------------------------------
   wire running = state != ST_RESET;
   wire globStart = frameRise && running;
   wire phaseDone = phaseCnt == CNT_ZERO;
   wire expStart = expRise && running;
   wire inGlobOrRead = state == ST_GLOBAL_SAMPLE || state == ST_READOUT;
   wire readEnd = state == ST_READOUT && phaseDone;

   // outside reset, a new frame request wins over the current phase
   always_comb
   begin
      next_state = state;
      if (globStart)
         next_state = ST_GLOBAL_SAMPLE;
      else
      begin
         case (state)
            ST_RESET: next_state = ST_IDLE;
            ST_IDLE: if (expRise) next_state = ST_EXPOSURE;
            ST_EXPOSURE: next_state = ST_EXPOSURE;
            ST_GLOBAL_SAMPLE: if (phaseDone) next_state = ST_READOUT;
            ST_READOUT:
               if (phaseDone)
                  next_state = (overlapExp || expRise) ? ST_EXPOSURE : ST_IDLE;
            default: next_state = ST_IDLE;
         endcase
      end
   end

   // phase counter times the sample and readout periods
   always_comb
   begin
      next_phase = phaseCnt;
      if (globStart)
         next_phase = GLOBAL_SAMPLE_STATE_LOAD;
      else if (state == ST_GLOBAL_SAMPLE && phaseDone)
         next_phase = READOUT_LOAD;
      else if (!phaseDone)
         next_phase = phaseCnt - CNT_ONE;
   end

   // soft reset abandons any frame in flight
   always_ff @(posedge mclk or negedge seqRstN)
   begin
      if (!seqRstN)
      begin
         state <= ST_RESET;
         phaseCnt <= CNT_ZERO;
         overlapExp <= 1'b0;
      end
      else
      begin
         state <= next_state;
         phaseCnt <= next_phase;
         overlapExp <= inGlobOrRead && (overlapExp || expRise) && !globStart && !readEnd;
      end
   end

   assign seqState = state;
   assign exposureActive = state == ST_EXPOSURE || overlapExp;
   assign readoutActive = state == ST_READOUT;
   assign softResetActive = !softRstN;

   // ----------------------------------------
   // shutter lag
   // ----------------------------------------
   // end lag always runs into the sample phase; start lag balances it
   always_ff @(posedge mclk or negedge seqRstN)
   begin
      if (!seqRstN)
      begin
         lagCnt <= CNT_ZERO;
         endCnt <= CNT_ZERO;
         integrating <= 1'b0;
      end
      else
      begin
         lagCnt <= expStart ? START_LAG_LOAD : (lagCnt == CNT_ZERO ? CNT_ZERO : lagCnt - CNT_ONE);
         endCnt <= globStart ? END_LAG_LOAD : (endCnt == CNT_ZERO ? CNT_ZERO : endCnt - CNT_ONE);
         if (expStart)
            integrating <= noLag;
         else if (exposureActive && lagCnt == CNT_ZERO)
            integrating <= 1'b1;
         else if (!exposureActive && endCnt == CNT_ZERO && !globStart)
            integrating <= 1'b0;
      end
   end

   // ----------------------------------------
   // active configuration copies
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_COUNT; gi++)
      begin : g_sync
         wire syncWe = memWe && bankSel == BANK0 && wrAddr == 7'(SYNC_BASE + gi);
         assign syncShadow[gi*8 +: 8] = mem[BANK0][7'(SYNC_BASE + gi)];
         assign syncConfig[gi*8 +: 8] = syncActive[gi];
         // with bypass off, the copy at frame start keeps one configuration per frame; a bypass write lands at once
         always_ff @(posedge mclk or negedge seqRstN)
         begin
            if (!seqRstN)
               syncActive[gi] <= REG_RESET;
            else if (bypass && syncWe)
               syncActive[gi] <= wrData;
            else if (globStart && !hold)
               syncActive[gi] <= syncShadow[gi*8 +: 8];
         end
      end
      for (gi = 0; gi < FRAME_COUNT; gi++)
      begin : g_frame
         assign frameShadow[gi*8 +: 8] = mem[BANK0][7'(FRAME_BASE + gi)];
         // timing only looked at on an exposure request
         always_ff @(posedge mclk or negedge seqRstN)
         begin
            if (!seqRstN)
               frameConfig[gi*8 +: 8] <= REG_RESET;
            else if (expStart)
               frameConfig[gi*8 +: 8] <= frameShadow[gi*8 +: 8];
         end
      end
   endgenerate

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!seqRstN);

   sequence sGlobRun;
      globStart ##1 (!frameRise)[*8];
   endsequence
   sequence sQuietEnd;
      readEnd && !frameRise && !expRise;
   endsequence

   AST_IDLE_AFTER_RESET: assert property (state == ST_RESET |=> state == ST_IDLE)
      else $error("reset exit did not reach idle");
   AST_EXP_ON_REQ: assert property (state == ST_IDLE && expRise && !frameRise
      |=> state == ST_EXPOSURE && exposureActive)
      else $error("exposure request ignored in idle");
   AST_GLOBAL_SAMPLE_STATE_ON_FRAME: assert property (state == ST_EXPOSURE && frameRise
      |=> state == ST_GLOBAL_SAMPLE && !exposureActive)
      else $error("frame request did not start global sample");
   AST_GLOBAL_SAMPLE_STATE_TO_READOUT: assert property (sGlobRun |-> ##[1:AST_GLOBAL_SAMPLE_STATE_MAX] readoutActive)
      else $error("global sample did not lead to readout");
   AST_READ_END_IDLE: assert property ((sQuietEnd and !overlapExp) |=> state == ST_IDLE)
      else $error("readout end without exposure did not return idle");
   AST_READ_END_EXP: assert property ((sQuietEnd and overlapExp)
      |=> state == ST_EXPOSURE ##1 state == ST_EXPOSURE)
      else $error("pending exposure lost at readout end");
   AST_SYNC_COPY: assert property (globStart && !hold && !bypass
      |=> syncConfig == $past(syncShadow))
      else $error("frame start copy missing");
   AST_SYNC_HOLD: assert property (globStart && hold && !wrStb |=> $stable(syncConfig))
      else $error("held configuration changed at frame start");
   AST_BYPASS: assert property (bypass && memWe && wrCat == CAT_SYNC
      |=> syncActive[$past(wrAddr[1:0])] == $past(wrData))
      else $error("bypass write not applied at once");
   AST_RO_DROP: assert property (wrStb && wrCat == CAT_READONLY |-> !memWe)
      else $error("read-only write reached the bank");
   AST_NO_LAG: assert property (noLag && expStart |=> integrating)
      else $error("integration did not start with exposure");
   // the lag counter holds integration off for the first ten cycles of exposure
   AST_LAG: assert property (!noLag && expStart |=> !integrating[*8])
      else $error("integration began before start lag");
   AST_FRAME_SAMPLE: assert property (expStart |=> frameConfig == $past(frameShadow))
      else $error("frame timing not sampled on exposure request");
endmodule

/* File: verilog/frame_seq_pkg.sv */
package frame_seq_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [1:0] BANK0 = 2'h0;
   localparam int BANKS = 4;
   localparam int ADDRS = 128;
   localparam logic [6:0] ADDR_BANK_SEL = 7'h00;
   localparam logic [6:0] ADDR_FRAME_SYNC_BYPASS = 7'h01;
   localparam logic [6:0] ADDR_SYNC_UPDATE_HOLD = 7'h02;
   localparam logic [6:0] ADDR_SOFT_RESET_CONTROL = 7'h03;
   localparam logic [6:0] ADDR_START_LAG_DISABLE = 7'h75;
   localparam logic [6:0] SYNC_BASE = 7'h10;
   localparam logic [6:0] SYNC_LAST = 7'h13;
   localparam int SYNC_COUNT = 4;
   localparam logic [6:0] FRAME_BASE = 7'h20;
   localparam logic [6:0] FRAME_LAST = 7'h21;
   localparam int FRAME_COUNT = 2;
   localparam logic [6:0] ADDR_IDLE_ONLY = 7'h30;
   localparam logic [6:0] ADDR_RESET_ONLY = 7'h31;
   localparam logic [6:0] ADDR_STATUS = 7'h7e;
   localparam int CTRL_BIT = 0;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] SOFT_RESET_DEFAULT = 8'h01;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int GLOBAL_SAMPLE_STATE_TIME_NS = 2000;
   localparam int READOUT_TIME_NS = 20000;
   localparam int START_LAG_NS = 400;
   localparam int END_LAG_NS = 400;
   localparam int GLOBAL_SAMPLE_STATE_CYCLES = (GLOBAL_SAMPLE_STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READOUT_CYCLES = (READOUT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int START_LAG_CYCLES = (START_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int END_LAG_CYCLES = (END_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] GLOBAL_SAMPLE_STATE_LOAD = CNT_W'(GLOBAL_SAMPLE_STATE_CYCLES - 1);
   localparam logic [CNT_W-1:0] READOUT_LOAD = CNT_W'(READOUT_CYCLES - 1);
   localparam logic [CNT_W-1:0] START_LAG_LOAD = CNT_W'(START_LAG_CYCLES - 1);
   localparam logic [CNT_W-1:0] END_LAG_LOAD = CNT_W'(END_LAG_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_RESET = 3'h0,
      ST_IDLE = 3'h1,
      ST_EXPOSURE = 3'h3,
      ST_GLOBAL_SAMPLE = 3'h2,
      ST_READOUT = 3'h6
   } state_t;

   typedef enum logic [2:0] {
      CAT_NONE, CAT_SYNC, CAT_FRAME, CAT_IDLE_ONLY, CAT_RESET_ONLY, CAT_READONLY
   } cat_t;

   // update category of a register
   function automatic cat_t regCategory(input logic [1:0] bank, input logic [6:0] addr);
      cat_t c;
      c = CAT_NONE;
      if (bank == BANK0)
      begin
         if (addr >= SYNC_BASE && addr <= SYNC_LAST) c = CAT_SYNC;
         else if (addr >= FRAME_BASE && addr <= FRAME_LAST) c = CAT_FRAME;
         else if (addr == ADDR_IDLE_ONLY) c = CAT_IDLE_ONLY;
         else if (addr == ADDR_RESET_ONLY) c = CAT_RESET_ONLY;
         else if (addr == ADDR_STATUS) c = CAT_READONLY;
      end
      return c;
   endfunction
endpackage

/* File: verilog/edge_sync.sv */
`timescale 1ns/1ps
module edge_sync
   import frame_seq_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // raw inputs
   input wire logic [WIDTH-1:0] din,
   // synchronised level and edges
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stable;
   logic [WIDTH-1:0] prev;

   // ----------------------------------------
   // two-flop synchroniser plus edge history
   // ----------------------------------------
   // meta feeds only stable, so edges never see a metastable value
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta <= '0;
         stable <= '0;
         prev <= '0;
      end
      else
      begin
         meta <= din;
         stable <= meta;
         prev <= stable;
      end
   end

   // edges from the settled stages
   assign level = stable;
   assign rise = stable & ~prev;
   assign fall = ~stable & prev;
endmodule

/* File: verilog/spi_target.sv */
`timescale 1ns/1ps
module spi_target
   import frame_seq_pkg::*;
(
   // clock and hard reset
   input wire logic mclk,
   input wire logic nrst,
   // synchronised serial pins
   input wire logic csNLvl,
   input wire logic sckRise,
   input wire logic sckFall,
   input wire logic mosiLvl,
   // register access
   output logic wrStb,
   output logic [6:0] wrAddr,
   output logic [7:0] wrData,
   output logic [6:0] rdAddr,
   input wire logic [7:0] rdData,
   // data out pin
   output logic misoOut,
   output logic misoOeN
);
   logic [2:0] bitCnt;
   logic inHeader;
   logic isWrite;
   logic byteDone;
   logic byteIsHdr;
   logic [6:0] curAddr;
   logic [7:0] inShift;
   logic [7:0] outShift;

   // ----------------------------------------
   // bit assembly
   // ----------------------------------------
   wire [7:0] next_in = {inShift[6:0], mosiLvl};
   wire lastBit = bitCnt == BIT_LAST;

   // header then bytes; commit and launch on the falling edge after a byte
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         bitCnt <= '0;
         inHeader <= 1'b1;
         isWrite <= 1'b0;
         byteDone <= 1'b0;
         byteIsHdr <= 1'b0;
         curAddr <= '0;
         inShift <= '0;
         outShift <= '0;
         wrStb <= 1'b0;
         wrAddr <= '0;
         wrData <= '0;
         misoOeN <= 1'b1;
      end
      else if (csNLvl)
      begin
         bitCnt <= '0;
         inHeader <= 1'b1;
         byteDone <= 1'b0;
         wrStb <= 1'b0;
         misoOeN <= 1'b1;
      end
      else
      begin
         wrStb <= 1'b0;
         if (sckRise)
         begin
            inShift <= next_in;
            bitCnt <= bitCnt + 3'h1;
            if (lastBit)
            begin
               byteDone <= 1'b1;
               byteIsHdr <= inHeader;
               inHeader <= 1'b0;
               if (inHeader)
               begin
                  isWrite <= next_in[7];
                  curAddr <= next_in[6:0];
               end
            end
         end
         if (sckFall && byteDone)
         begin
            byteDone <= 1'b0;
            if (!isWrite)
            begin
               outShift <= rdData;
               misoOeN <= 1'b0;
               curAddr <= curAddr + 7'h01;
            end
            else if (!byteIsHdr)
            begin
               wrStb <= 1'b1;
               wrData <= inShift;
               wrAddr <= curAddr;
               curAddr <= curAddr + 7'h01;
            end
         end
         else if (sckFall)
            outShift <= {outShift[6:0], 1'b0};
      end
   end

   // read data goes out msb first
   assign misoOut = outShift[7];
   assign rdAddr = curAddr;
endmodule

/* File: verification/camera_controller.sv */
`timescale 1ns/1ps
module camera_controller
(
   // clock
   input wire logic mclk,
   // serial pins
   output logic spiCsN,
   output logic spiClk,
   output logic spiMosi,
   input wire logic spiMisoOut,
   input wire logic spiMisoOeN,
   // request pins
   output logic exposureRequest,
   output logic frameRequest
);
   // ----------------------------------------
   // serial master and request driver
   // ----------------------------------------
   // idle levels; serial clock stands still between frames
   initial
   begin
      spiCsN = 1'b1;
      spiClk = 1'b0;
      spiMosi = 1'b0;
      exposureRequest = 1'b0;
      frameRequest = 1'b0;
   end

   // one bit, 8 mclk per half period to stay under mclk/8
   task automatic sbit(input logic b, output logic q);
      spiMosi <= b;
      repeat (7) @(posedge mclk);
      @(negedge mclk);
      q = spiMisoOeN ? 1'bx : spiMisoOut; // undriven line never matches
      @(posedge mclk);
      spiClk <= 1'b1;
      repeat (8) @(posedge mclk);
      spiClk <= 1'b0;
   endtask

   // control bit, address, one byte, msb first
   task automatic access(input logic wr, input logic [6:0] a,
      input logic [7:0] d, output logic [7:0] q);
      logic [15:0] f;
      logic b;
      f = {wr, a, d};
      @(posedge mclk);
      spiCsN <= 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         sbit(f[i], b);
         if (i < 8) q[i] = b;
      end
      repeat (8) @(posedge mclk);
      spiCsN <= 1'b1;
      spiMosi <= ~spiMosi; // released line shows no stale value
   endtask

   // level held long enough for the two-flop sync
   task automatic pulse(input logic fr);
      @(posedge mclk);
      if (fr) frameRequest <= 1'b1;
      else exposureRequest <= 1'b1;
      repeat (6) @(posedge mclk);
      frameRequest <= 1'b0;
      exposureRequest <= 1'b0;
   endtask
endmodule

/* File: verification/frame_state_sequencer_bench.sv */
`timescale 1ns/1ps
module frame_state_sequencer_bench;
   import frame_seq_pkg::*;
   logic mclk, nrst;
   // pin nets are driven by the controller model and the design
   wire logic spiCsN, spiClk, spiMosi, spiMisoOut, spiMisoOeN;
   wire logic exposureRequest, frameRequest;
   wire logic [2:0] seqState;
   wire logic exposureActive, integrating, readoutActive, softResetActive;
   wire logic [SYNC_COUNT*8-1:0] syncConfig;
   wire logic [FRAME_COUNT*8-1:0] frameConfig;
   logic [7:0] q, v, w;
   int fail_count = 0;
   int n_compared = 0;
   int seed = 86628;

   frame_state_sequencer uut (.mclk(mclk), .nrst(nrst), .exposureRequest(exposureRequest),
      .frameRequest(frameRequest), .spiCsN(spiCsN), .spiClk(spiClk), .spiMosi(spiMosi),
      .spiMisoOut(spiMisoOut), .spiMisoOeN(spiMisoOeN), .seqState(seqState),
      .exposureActive(exposureActive), .integrating(integrating),
      .readoutActive(readoutActive), .softResetActive(softResetActive),
      .syncConfig(syncConfig), .frameConfig(frameConfig));
   camera_controller ctrl (.mclk(mclk), .spiCsN(spiCsN), .spiClk(spiClk),
      .spiMosi(spiMosi), .spiMisoOut(spiMisoOut), .spiMisoOeN(spiMisoOeN),
      .exposureRequest(exposureRequest), .frameRequest(frameRequest));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // 25 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic chk(input logic ok, input string what);
      n_compared++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      ctrl.access(1'b1, a, d, q);
   endtask

   task automatic rdChk(input logic [6:0] a, input logic [7:0] e);
      ctrl.access(1'b0, a, 8'h00, q);
      chk(q === e, "read value");
   endtask

   // bounded wait; a count outside lo..hi is a timing fault
   task automatic waitSt(input state_t st, input int lo, input int hi);
      int n;
      n = 0;
      while (seqState !== st && n <= hi)
      begin
         @(negedge mclk);
         n++;
      end
      chk(n >= lo && n <= hi, "state timing");
   endtask

   // status byte expected in a quiet state
   function automatic logic [7:0] stat(input logic [2:0] s);
      return {2'b00, s == ST_READOUT, 2'b00, s};
   endfunction

   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // watchdog well past the expected run of some 10k cycles
   initial
   begin
      #2_000_000;
      fail_count++;
      print_verdict();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      nrst = 1'b0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      chk(seqState === ST_IDLE, "idle after reset");
      rdChk(ADDR_FRAME_SYNC_BYPASS, REG_RESET);
      rdChk(ADDR_SOFT_RESET_CONTROL, SOFT_RESET_DEFAULT);
      rdChk(ADDR_START_LAG_DISABLE, REG_RESET);
      wr(ADDR_STATUS, 8'hff);
      rdChk(ADDR_STATUS, stat(ST_IDLE));
      v = $random(seed);
      w = $random(seed);
      wr(7'h40, v);
      rdChk(7'h40, v);
      wr(ADDR_IDLE_ONLY, w); // written in idle
      rdChk(ADDR_IDLE_ONLY, w);
      // other banks hold their own copies; address 0 reachable everywhere
      wr(ADDR_BANK_SEL, 8'h01);
      wr(7'h40, w);
      rdChk(ADDR_BANK_SEL, 8'h01);
      rdChk(7'h40, w);
      wr(ADDR_BANK_SEL, 8'h00);
      rdChk(7'h40, v);
      $display("test registers done");
      // sequential frame with start lag
      wr(SYNC_BASE, v);
      wr(FRAME_BASE, w);
      rdChk(SYNC_BASE, v);
      chk(syncConfig[7:0] === 8'h00, "sync early");
      ctrl.pulse(1'b0);
      chk(seqState === ST_EXPOSURE, "exposure");
      chk(frameConfig[7:0] === w, "frame sampled");
      chk(integrating === 1'b0, "start lag");
      wr(FRAME_BASE, ~w);
      chk(frameConfig[7:0] === w && integrating === 1'b1, "frame held");
      ctrl.pulse(1'b1);
      chk(seqState === ST_GLOBAL_SAMPLE, "sample");
      chk(syncConfig[7:0] === v && integrating === 1'b1, "copy");
      waitSt(ST_READOUT, GLOBAL_SAMPLE_STATE_CYCLES - 6, GLOBAL_SAMPLE_STATE_CYCLES + 2);
      waitSt(ST_IDLE, READOUT_CYCLES - 2, READOUT_CYCLES + 2);
      $display("test sequential done");
      // hold freezes, bypass acts at once
      wr(ADDR_SYNC_UPDATE_HOLD, 8'h01); // hold over the update
      wr(SYNC_BASE + 7'h1, v);
      wr(ADDR_FRAME_SYNC_BYPASS, 8'h01);
      wr(SYNC_BASE + 7'h2, w);
      chk(syncConfig[23:16] === w, "bypass");
      wr(ADDR_FRAME_SYNC_BYPASS, 8'h00);
      ctrl.pulse(1'b0);
      ctrl.pulse(1'b1);
      chk(syncConfig[15:8] === 8'h00, "hold");
      waitSt(ST_IDLE, 0, GLOBAL_SAMPLE_STATE_CYCLES + READOUT_CYCLES);
      $display("test hold done");
      // pipelined frames without start lag
      wr(ADDR_SYNC_UPDATE_HOLD, 8'h00);
      wr(ADDR_START_LAG_DISABLE, 8'h01);
      ctrl.pulse(1'b0);
      chk(integrating === 1'b1, "no lag");
      ctrl.pulse(1'b1);
      chk(syncConfig[15:8] === v, "hold off");
      waitSt(ST_READOUT, GLOBAL_SAMPLE_STATE_CYCLES - 6, GLOBAL_SAMPLE_STATE_CYCLES + 2);
      ctrl.pulse(1'b0);
      chk(seqState === ST_READOUT && readoutActive === 1'b1 && exposureActive === 1'b1,
         "overlap");
      waitSt(ST_EXPOSURE, READOUT_CYCLES - 10, READOUT_CYCLES);
      ctrl.pulse(1'b1);
      chk(seqState === ST_GLOBAL_SAMPLE, "next sample");
      $display("test pipelined done");
      // soft reset abandons the frame, keeps registers
      wr(ADDR_SOFT_RESET_CONTROL, 8'h00);
      chk(seqState === ST_RESET && softResetActive === 1'b1, "soft");
      chk(syncConfig === '0, "soft clears active");
      ctrl.pulse(1'b0);
      chk(seqState === ST_RESET, "ignored");
      wr(ADDR_RESET_ONLY, v); // written in soft reset
      rdChk(SYNC_BASE, v);
      wr(ADDR_SOFT_RESET_CONTROL, 8'h01);
      chk(seqState === ST_IDLE, "soft release");
      rdChk(ADDR_RESET_ONLY, v);
      $display("test soft reset done");
      // hard reset clears the bank
      nrst <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(seqState === ST_RESET, "hard");
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      rdChk(SYNC_BASE, REG_RESET);
      $display("test hard reset done");
      print_verdict();
   end
endmodule
